/* File: design/tdc_ctrl_pkg.sv */
/*
 holds the constants and carrier types of the reset, timer and flag control block.
 assumes a 50 MHz reference clock and a single AHB-Lite master.
*/
package tdc_ctrl_pkg;
	// clock and timing
	localparam int unsigned CLK_PERIOD_PS    = 20000;
	localparam int unsigned BLANK_MASTER_PS  = 40000;
	localparam int unsigned BLANK_PARTIAL_PS = 75000;
	localparam int unsigned BLANK_MASTER_CYC  = (BLANK_MASTER_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned BLANK_PARTIAL_CYC = (BLANK_PARTIAL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned BLANK_W = 3;
	// register indices, byte address is four times the index
	localparam logic [3:0] IDX_TEST    = 4'h3;
	localparam logic [3:0] IDX_CTRL    = 4'h4;
	localparam logic [3:0] IDX_PINRST  = 4'h5;
	localparam logic [3:0] IDX_TIMER   = 4'h7;
	localparam logic [3:0] IDX_ERRMASK = 4'hB;
	localparam logic [3:0] IDX_IRQMASK = 4'hC;
	localparam logic [3:0] IDX_STATUS  = 4'hF;
	// test select register
	localparam int unsigned TEST_SEL = 0;
	// control register fields
	localparam int unsigned CTRL_MRST   = 0;
	localparam int unsigned CTRL_PRST   = 1;
	localparam int unsigned CTRL_TSTART = 2;
	localparam int unsigned CTRL_TSTOP  = 3;
	localparam int unsigned CTRL_QUIET  = 4;
	localparam int unsigned CTRL_SWTRIG = 5;
	localparam int unsigned CTRL_DEL    = 6;
	localparam int unsigned DEL_W       = 3;
	localparam logic [DEL_W-1:0] DEL_RESET = 3'h1;
	// pin reset register fields
	localparam int unsigned PIN_MTRIG = 0;
	localparam int unsigned PIN_MOEN  = 1;
	localparam int unsigned PIN_PTRIG = 2;
	localparam int unsigned PIN_POEN  = 3;
	localparam int unsigned PIN_OEN_USED = 4;
	// timer, mask and status fields
	localparam int unsigned TIMER_W = 13;
	localparam int unsigned IRQ_LSB = 13;
	localparam int unsigned IRQ_W   = 13;
	localparam int unsigned ERR_LSB = 16;
	localparam int unsigned ERR_W   = 11;
	localparam int unsigned ST_ACCEPT = 0;
	localparam int unsigned ST_TBUSY  = 1;
	localparam int unsigned ST_TDONE  = 2;
	localparam int unsigned ST_IRQ    = 3;
	localparam int unsigned ST_ERR    = 4;
	localparam int unsigned ST_PPR    = 16;
	// pulse-pair resolution in ps: base plus step per delay setting
	localparam logic [15:0] PPR_BASE_PS = 16'h1194;
	localparam logic [15:0] PPR_STEP_PS = 16'h03E8;

	// event sources from the measurement core
	typedef struct packed {
		logic [7:0] hit_full;
		logic [7:0] hit_empty;
		logic [1:0] iface_full;
		logic       pll_locked;
	} core_status_t;

	// AHB-Lite request and answer
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
		logic [31:0] hwdata;
	} ahb_req_t;

	typedef struct packed {
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
	} ahb_rsp_t;
endpackage

/* File: design/reset_timer_flag_control.sv */
/*
 holds the reset paths, input blanking, interval timer, flag logic, test input mux
 and AHB-Lite register slave of the converter control block.
 assumes all inputs synchronous to clock_i and a single-master AHB-Lite bus.
*/
// How it works
// - power-up reset clears all configuration except delay setting which loads 1, loads master blanking and holds core and fifo resets high
// - software write issues master reset
// - partial reset keeps configuration and interface FIFOs
// - non-quiet: trigger pin high gives master reset
// - quiet: output enable low gives master reset
// - non-quiet: trigger pin high gives partial reset
// - quiet: output enable low gives partial reset
// - inputs blocked 40 ns after master reset
// - inputs blocked 75 ns after partial reset
// - timer period counted in reference clock cycles
// - timer started by start, stop or both
// - timer expiry raises interrupt when enabled
// - interrupt is OR of unmasked sources
// - interrupt sources: fifos full, pll, empty, timer
// - error is OR of unmasked fault sources
// - test select routes test inputs instead
// - delay setting selects pulse-pair resolution
// - quiet mode processes only on trigger
module reset_timer_flag_control
	import tdc_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic                      clock_i,
	input  wire logic                      rstn_i,
	// register bus
	input  wire tdc_ctrl_pkg::ahb_req_t    ahb_i,
	output      tdc_ctrl_pkg::ahb_rsp_t    ahb_o,
	// pins and core status
	input  wire logic                      trigger_pin_i,
	input  wire logic                      output_enable_n_i,
	input  wire logic                      start_event_i,
	input  wire logic                      stop_event_i,
	input  wire tdc_ctrl_pkg::core_status_t core_i,
	input  wire logic [2:0]                meas_i,
	input  wire logic [2:0]                test_meas_i,
	// outputs to the core and pins
	output      logic [2:0]                meas_o,
	output      logic                      core_reset_o,
	output      logic                      fifo_reset_o,
	output      logic                      alu_trigger_o,
	output      logic [DEL_W-1:0]          delay_select_o,
	output      logic                      interrupt_flag_o,
	output      logic                      error_flag_o
);
	import tdc_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// configuration and state
	logic                 test_sel;
	logic [3:1]           ctrl_keep;
	logic [DEL_W-1:0]     processing_delay_select;
	logic [4:0]           pinrst;
	logic [TIMER_W-1:0]   period;
	logic [ERR_W-1:0]     err_mask;
	logic [IRQ_W-1:0]     irq_mask;
	logic [BLANK_W-1:0]   blank_cnt;
	logic [TIMER_W-1:0]   timer_cnt;
	logic                 timer_busy;
	logic                 timer_done;
	logic                 trig_q;
	logic                 wr_pend;
	logic                 rd_pend;
	logic [3:0]           a_idx;
	logic                 a_ok;

	////////////////////////////////////////////////////////////////////////////
	// bus decode
	wire take      = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;
	wire addr_ok   = (ahb_i.haddr[31:6] == 26'h0) & (ahb_i.haddr[1:0] == 2'h0);
	wire wr_now    = wr_pend & a_ok;
	wire wr_test   = wr_now & (a_idx == IDX_TEST);
	wire wr_ctrl   = wr_now & (a_idx == IDX_CTRL);
	wire wr_pinrst = wr_now & (a_idx == IDX_PINRST);
	wire wr_timer  = wr_now & (a_idx == IDX_TIMER);
	wire wr_err    = wr_now & (a_idx == IDX_ERRMASK);
	wire wr_irq    = wr_now & (a_idx == IDX_IRQMASK);
	wire [31:0] wd = ahb_i.hwdata;

	// configuration views
	wire quiet       = ctrl_keep[3];
	wire timer_start = ctrl_keep[1];
	wire timer_stop  = ctrl_keep[2];
	wire master_reset_by_trigger_pin       = pinrst[PIN_MTRIG];
	wire master_reset_by_output_enable_pin = pinrst[PIN_MOEN];
	wire partial_reset_by_trigger_pin      = pinrst[PIN_PTRIG];
	wire partial_reset_by_output_enable_pin = pinrst[PIN_POEN];
	wire oen_free    = ~pinrst[PIN_OEN_USED];

	////////////////////////////////////////////////////////////////////////////
	// reset requests
	wire sw_mrst  = wr_ctrl & wd[CTRL_MRST];
	wire sw_prst  = wr_ctrl & wd[CTRL_PRST];
	wire sw_trig  = wr_ctrl & wd[CTRL_SWTRIG];
	wire oen_low  = quiet & oen_free & ~output_enable_n_i;
	wire pin_mrst = (~quiet & master_reset_by_trigger_pin & trigger_pin_i)
		| (master_reset_by_output_enable_pin & oen_low);
	wire pin_prst = (~quiet & partial_reset_by_trigger_pin & trigger_pin_i)
		| (partial_reset_by_output_enable_pin & oen_low);
	wire do_master = sw_mrst | pin_mrst;
	wire do_partial = (sw_prst | pin_prst) & ~do_master;
	wire rst_any   = do_master | do_partial;

	// event gating and timer start
	wire accepting  = (blank_cnt == '0);
	wire ev_start   = start_event_i & accepting;
	wire ev_stop    = stop_event_i & accepting;
	wire timer_kick = (timer_start & ev_start) | (timer_stop & ev_stop);
	wire expire     = timer_busy & ~timer_kick & (timer_cnt <= 13'h0001);

	// flag sources
	wire [IRQ_W-1:0] irq_src = {timer_done, &core_i.hit_empty, ~core_i.pll_locked,
		core_i.iface_full, core_i.hit_full};
	wire [ERR_W-1:0] err_src = {~core_i.pll_locked, core_i.iface_full, core_i.hit_full};
	wire next_irq = |(irq_src & irq_mask);
	wire next_err = |(err_src & err_mask);

	// post-processing start and resolution
	wire trig_rise = trigger_pin_i & ~trig_q;
	wire next_alu  = quiet ? (trig_rise | sw_trig) : (ev_start | ev_stop);
	wire [15:0] ppr_ps = PPR_BASE_PS + 16'(processing_delay_select) * PPR_STEP_PS;

	// read data
	wire [31:0] status = {ppr_ps, 11'h0, error_flag_o, interrupt_flag_o, timer_done, timer_busy, accepting};
	wire [31:0] rdata =
		!a_ok ? 32'h0000_0000 :
		(a_idx == IDX_TEST) ? {31'h0, test_sel} :
		(a_idx == IDX_CTRL) ? {23'h0, processing_delay_select, 1'b0, quiet, timer_stop, timer_start, 2'h0} :
		(a_idx == IDX_PINRST) ? {27'h0, pinrst} :
		(a_idx == IDX_TIMER) ? {19'h0, period} :
		(a_idx == IDX_ERRMASK) ? {5'h0, err_mask, 16'h0} :
		(a_idx == IDX_IRQMASK) ? {6'h0, irq_mask, 13'h0} :
		(a_idx == IDX_STATUS) ? status : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// bus slave: writes without wait, reads with one wait state
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			a_idx   <= 4'h0;
			a_ok    <= 1'b0;
			ahb_o   <= '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h0000_0000};
		end else begin
			wr_pend <= take & ahb_i.hwrite;
			rd_pend <= take & ~ahb_i.hwrite;
			if (take) begin
				a_idx <= ahb_i.haddr[5:2];
				a_ok  <= addr_ok;
			end
			ahb_o.hreadyout <= ~(take & ~ahb_i.hwrite);
			if (rd_pend)
				ahb_o.hrdata <= rdata;
		end
	end

	// configuration registers survive master and partial resets
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			test_sel <= 1'b0;
			ctrl_keep <= 3'h0;
			processing_delay_select <= DEL_RESET;
			pinrst <= 5'h00;
			period <= '0;
			err_mask <= '0;
			irq_mask <= '0;
		end else begin
			if (wr_test) test_sel <= wd[TEST_SEL];
			if (wr_ctrl) begin
				ctrl_keep <= {wd[CTRL_QUIET], wd[CTRL_TSTOP], wd[CTRL_TSTART]};
				processing_delay_select <= wd[CTRL_DEL +: DEL_W];
			end
			if (wr_pinrst) pinrst <= wd[4:0];
			if (wr_timer) period <= wd[TIMER_W-1:0];
			if (wr_err) err_mask <= wd[ERR_LSB +: ERR_W];
			if (wr_irq) irq_mask <= wd[IRQ_LSB +: IRQ_W];
		end
	end

	// input blanking after each kind of reset
	always_ff @(posedge clock_i) begin
		if (!rstn_i)
			blank_cnt <= BLANK_W'(BLANK_MASTER_CYC);
		else if (do_master)
			blank_cnt <= BLANK_W'(BLANK_MASTER_CYC);
		else if (do_partial)
			blank_cnt <= BLANK_W'(BLANK_PARTIAL_CYC);
		else if (!accepting)
			blank_cnt <= blank_cnt - 3'h1;
	end

	// interval timer, expiry sticks until restart or reset
	always_ff @(posedge clock_i) begin
		if (!rstn_i || rst_any) begin
			timer_cnt  <= '0;
			timer_busy <= 1'b0;
			timer_done <= 1'b0;
		end else begin
			if (timer_kick) begin
				timer_cnt  <= period;
				timer_busy <= 1'b1;
			end else if (timer_busy) begin
				timer_cnt  <= timer_cnt - 13'h0001;
				timer_busy <= ~expire;
			end
			timer_done <= expire | (timer_done & ~timer_kick);
		end
	end

	// outputs to the core and flags
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			trig_q <= 1'b0;
			meas_o <= 3'h0;
			core_reset_o <= 1'b1;
			fifo_reset_o <= 1'b1;
			alu_trigger_o <= 1'b0;
			delay_select_o <= DEL_RESET;
			interrupt_flag_o <= 1'b0;
			error_flag_o <= 1'b0;
		end else begin
			trig_q <= trigger_pin_i;
			meas_o <= test_sel ? test_meas_i : meas_i;
			core_reset_o <= rst_any;
			fifo_reset_o <= do_master;
			alu_trigger_o <= next_alu & ~rst_any;
			delay_select_o <= processing_delay_select;
			interrupt_flag_o <= next_irq;
			error_flag_o <= next_err;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	property p_master_blank;
		do_master |=> !accepting ##1 !accepting;
	endproperty
	a_master_blank: assert property (p_master_blank) else $error("master blanking too short");

	property p_master_open;
		do_master ##1 !rst_any ##1 !rst_any |=> accepting;
	endproperty
	a_master_open: assert property (p_master_open) else $error("master blanking too long");

	property p_partial_blank;
		do_partial ##1 !rst_any[*4] |-> !accepting && $past(!accepting, 3) ##1 accepting;
	endproperty
	a_partial_blank: assert property (p_partial_blank) else $error("partial blanking wrong");

	property p_partial_keeps_fifo;
		do_partial |=> core_reset_o && !fifo_reset_o;
	endproperty
	a_partial_keeps_fifo: assert property (p_partial_keeps_fifo) else $error("partial reset hit fifos");

	property p_pin_master;
		!quiet && master_reset_by_trigger_pin && trigger_pin_i |=> fifo_reset_o && !accepting;
	endproperty
	a_pin_master: assert property (p_pin_master) else $error("trigger pin master reset missing");

	property p_irq;
		next_irq |=> interrupt_flag_o ##1 (interrupt_flag_o == $past(next_irq));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt flag wrong");

	property p_err;
		!next_err |=> !error_flag_o;
	endproperty
	a_err: assert property (p_err) else $error("error flag raised without source");

	property p_timer_irq;
		expire && !rst_any && irq_mask[IRQ_W-1] |=> ##1 interrupt_flag_o;
	endproperty
	a_timer_irq: assert property (p_timer_irq) else $error("timer expiry did not interrupt");

	property p_test_mux;
		test_sel |=> meas_o == $past(test_meas_i);
	endproperty
	a_test_mux: assert property (p_test_mux) else $error("test inputs not routed");

	property p_quiet_trigger;
		quiet && (ev_start || ev_stop) && !trig_rise && !sw_trig |=> !alu_trigger_o;
	endproperty
	a_quiet_trigger: assert property (p_quiet_trigger) else $error("quiet mode processed on event");

	property p_self_clear;
		sw_mrst ##1 !rst_any |=> !core_reset_o;
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("software reset did not clear");

	c_master: cover property (do_master ##1 !rst_any[*3] ##1 accepting);
	c_partial: cover property (do_partial ##1 !rst_any[*5]);
	c_timer: cover property (timer_kick ##[1:20] expire);
	c_quiet_alu: cover property (quiet && trig_rise ##1 alu_trigger_o);
endmodule

/* File: sim/host_model.sv */
/*
 host model: single AHB-Lite master that issues one word transfer at a time.
 assumes one slave whose hreadyout is fed back as the bus hready.
*/
module host_model
	import tdc_ctrl_pkg::*;
(
	// clock
	input  wire logic                   clock_i,
	// register bus
	input  wire tdc_ctrl_pkg::ahb_rsp_t ahb_i,
	output      tdc_ctrl_pkg::ahb_req_t ahb_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        sel   = 1'b0;
	logic [31:0] addr  = 32'h0;
	logic [1:0]  trans = 2'h0;
	logic        wen   = 1'b0;
	logic [31:0] wdata = 32'h0;
	// hready of the single slave is its own hreadyout
	assign ahb_o = '{sel, addr, trans, wen, 3'h2, ahb_i.hreadyout, wdata};
	////////////////////////////////////////////////////////////////
	// address phase held until hready, then data phase until hready
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock_i);
		sel   <= 1'b1;
		addr  <= a;
		trans <= 2'h2;
		wen   <= w;
		do @(posedge clock_i); while (ahb_i.hreadyout !== 1'b1);
		sel   <= 1'b0;
		trans <= 2'h0;
		addr  <= ~a;
		wdata <= d;
		do @(posedge clock_i); while (ahb_i.hreadyout !== 1'b1);
		q = ahb_i.hrdata;
		// released data lines show no stale value
		wdata <= ~d;
	endtask
endmodule

/* File: sim/reset_timer_flag_control_test.sv */
/*
 testbench: register, reset, blanking, timer, flag and test mux checks.
 assumes host_model as bus master and the bench driving all pins.
*/
module reset_timer_flag_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import tdc_ctrl_pkg::*;
	logic         clock_i  = 1'b0;
	logic         rstn_i   = 1'b0;
	ahb_req_t     req;
	ahb_rsp_t     rsp;
	logic         trig     = 1'b0;
	logic         oen_n    = 1'b1;
	logic         start_ev = 1'b0;
	logic         stop_ev  = 1'b0;
	core_status_t core     = '{8'h0, 8'h0, 2'h0, 1'b1};
	logic [2:0]   meas     = 3'h5;
	logic [2:0]   tmeas    = 3'h2;
	logic [2:0]   meas_o;
	logic [2:0]   dsel;
	logic         core_rst, fifo_rst, alu, irq, err;
	logic [31:0]  q;
	int           fail_count = 0, n_tests = 0, cyc = 0, cc = 0, fc = 0, ac = 0;
	int           n, n5, n10, c0, f0, a0;
	logic [31:0]  pin_cfg [6] = '{32'h1, 32'h4, 32'h2, 32'h8, 32'h12, 32'h1};
	logic         pin_q   [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
	int           pin_c   [6] = '{3, 3, 3, 3, 0, 0};
	int           pin_f   [6] = '{3, 0, 3, 0, 0, 0};
	host_model h (.clock_i(clock_i), .ahb_i(rsp), .ahb_o(req));
	reset_timer_flag_control uut (.clock_i(clock_i), .rstn_i(rstn_i), .ahb_i(req), .ahb_o(rsp),
		.trigger_pin_i(trig), .output_enable_n_i(oen_n), .start_event_i(start_ev), .stop_event_i(stop_ev),
		.core_i(core), .meas_i(meas), .test_meas_i(tmeas), .meas_o(meas_o), .core_reset_o(core_rst),
		.fifo_reset_o(fifo_rst), .alu_trigger_o(alu), .delay_select_o(dsel),
		.interrupt_flag_o(irq), .error_flag_o(err));
	always #10 clock_i = ~clock_i;
	////////////////////////////////////////////////////////////////
	// cycle counts of reset and trigger outputs, plus hang limit
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		cc  <= cc + core_rst;
		fc  <= fc + fifo_rst;
		ac  <= ac + alu;
		if (cyc >= 20000) begin
			fail_count++;
			conclude();
		end
	end
	function automatic logic [31:0] ad(input logic [3:0] idx);
		return {26'h0, idx, 2'h0};
	endfunction
	// one event source per index, all others quiet
	function automatic core_status_t src(input int i);
		core_status_t c = '{8'h0, 8'h0, 2'h0, 1'b1};
		if (i < 8) c.hit_full[i] = 1'b1;
		else if (i < 10) c.iface_full[i-8] = 1'b1;
		else if (i == 10) c.pll_locked = 1'b0;
		else c.hit_empty = 8'hFF;
		return c;
	endfunction
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		h.xfer(a, 1'b1, d, dummy);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		h.xfer(a, 1'b0, 32'h0, d);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// start timer from reset, count cycles until the interrupt flag
	task automatic tmr(input logic [12:0] p, input logic [31:0] mode, input logic by_stop, output int k);
		wr(ad(IDX_TIMER), {19'h0, p});
		wr(ad(IDX_CTRL), 32'h41 | mode);
		repeat (6) @(posedge clock_i);
		if (by_stop) stop_ev <= 1'b1;
		else start_ev <= 1'b1;
		@(posedge clock_i);
		start_ev <= 1'b0;
		stop_ev  <= 1'b0;
		k = 0;
		while (irq !== 1'b1 && k < 60) begin
			@(posedge clock_i);
			k++;
		end
	endtask
	// start held high across a one-cycle trigger pin reset
	task automatic blank(input logic [31:0] cfg, output int k);
		int b0;
		wr(ad(IDX_PINRST), cfg);
		repeat (4) @(posedge clock_i);
		b0 = ac;
		trig     <= 1'b1;
		start_ev <= 1'b1;
		@(posedge clock_i);
		trig <= 1'b0;
		repeat (9) @(posedge clock_i);
		start_ev <= 1'b0;
		repeat (4) @(posedge clock_i);
		k = ac - b0;
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (12) @(posedge clock_i);
		rstn_i <= 1'b1;
		rd(ad(IDX_CTRL), q);
		check(q, 32'h40);
		rd(ad(IDX_STATUS), q);
		check(q, 32'h157C0001);
		for (int d = 1; d <= 4; d++) begin
			wr(ad(IDX_CTRL), d << CTRL_DEL);
			rd(ad(IDX_STATUS), q);
			check(q[31:16], 4500 + 1000 * d);
			check(dsel, d);
		end
		wr(ad(4'h1), 32'hFFFFFFFF);
		rd(ad(4'h1), q);
		check(q, 32'h0);
		check(rsp.hresp, 1'b0);
		@(posedge clock_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		rstn_i <= 1'b1;
		rd(ad(IDX_CTRL), q);
		check(q, 32'h40);
		$display("test registers done");
		// software resets: master clears fifos too, partial does not
		for (int s = 0; s < 2; s++) begin
			c0 = cc;
			f0 = fc;
			wr(ad(IDX_CTRL), 32'h41 + s);
			repeat (4) @(posedge clock_i);
			check(cc - c0, 1);
			check(fc - f0, 1 - s);
			rd(ad(IDX_CTRL), q);
			check(q, 32'h40);
		end
		// pin resets in each mode, held three cycles
		for (int i = 0; i < 6; i++) begin
			wr(ad(IDX_CTRL), pin_q[i] ? 32'h50 : 32'h40);
			wr(ad(IDX_PINRST), pin_cfg[i]);
			repeat (4) @(posedge clock_i);
			c0 = cc;
			f0 = fc;
			if (pin_cfg[i] & 32'h5) trig <= 1'b1;
			else oen_n <= 1'b0;
			repeat (3) @(posedge clock_i);
			trig  <= 1'b0;
			oen_n <= 1'b1;
			repeat (4) @(posedge clock_i);
			check(cc - c0, pin_c[i]);
			check(fc - f0, pin_f[i]);
		end
		$display("test resets done");
		wr(ad(IDX_CTRL), 32'h40);
		blank(32'h1, n);
		blank(32'h4, n5);
		check(n - n5, 2);
		// quiet mode: pin edge and software bit each give one trigger
		wr(ad(IDX_PINRST), 32'h0);
		wr(ad(IDX_CTRL), 32'h50);
		a0 = ac;
		trig <= 1'b1;
		repeat (3) @(posedge clock_i);
		trig <= 1'b0;
		repeat (3) @(posedge clock_i);
		check(ac - a0, 1);
		a0 = ac;
		wr(ad(IDX_CTRL), 32'h70);
		repeat (3) @(posedge clock_i);
		check(ac - a0, 1);
		// quiet mode: an accepted start event alone gives no trigger
		a0 = ac;
		start_ev <= 1'b1;
		@(posedge clock_i);
		start_ev <= 1'b0;
		repeat (3) @(posedge clock_i);
		check(ac - a0, 0);
		$display("test blanking done");
		wr(ad(IDX_IRQMASK), 32'h02000000);
		tmr(5, 32'h4, 1'b0, n5);
		tmr(10, 32'h4, 1'b0, n10);
		check(n10 - n5, 5);
		check(n5 < 60, 1);
		tmr(5, 32'h8, 1'b0, n);
		check(n, 60);
		tmr(5, 32'h8, 1'b1, n);
		check(n, n5);
		tmr(5, 32'hC, 1'b1, n);
		check(n, n5);
		$display("test timer done");
		for (int i = 0; i < 12; i++) begin
			core <= src(i);
			wr(ad(IDX_ERRMASK), 32'h1 << (16 + i % 11));
			wr(ad(IDX_IRQMASK), 32'h1 << (13 + i));
			repeat (3) @(posedge clock_i);
			check(err, i < 11);
			check(irq, 1);
			wr(ad(IDX_ERRMASK), 32'h1 << (16 + (i + 1) % 11));
			wr(ad(IDX_IRQMASK), 32'h1 << (13 + (i + 1) % 12));
			repeat (3) @(posedge clock_i);
			check(err, 0);
			check(irq, 0);
		end
		$display("test flags done");
		check(meas_o, 3'h5);
		wr(ad(IDX_TEST), 32'h1);
		repeat (2) @(posedge clock_i);
		check(meas_o, 3'h2);
		$display("test mux done");
		conclude();
	end
endmodule
